// ===== design/edge_status_disk_change.sv
// Edge status, forced disk change and interrupt registers on AXI4-Lite
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps

// Contract
// R1 - Writing one to any of misc status bits 5..0 clears it, zero keeps it.
// R2 - Status bits 0..2 set on any edge of edge inputs 0..2.
// R3 - Status bits 3..5 set on any edge of edge inputs 3..5.
// R4 - Misc status bits 7..6 always read as zero.
// R5 - The reserved slot at index 1D reads as zero.
// R6 - Force bit 0 acts for drive 0 and bit 1 for drive 1, one active.
// R7 - Software sets a force bit by writing one and cannot clear it.
// R8 - Force bit 0 is cleared by head step or drive 0 select activity.
// R9 - Force bit 1 is cleared by head step or drive 1 select activity.
// R10 - Disk changed is media OR force 0 on drive 0 OR force 1 on drive 1.
// R11 - Pins are synchronised before edge detection and a set beats a clear.
module edge_status_disk_change
    import edge_disk_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              ce,
    input  wire logic              rst_n,
    input  wire logic              standbyRst_n,
    input  wire axi_lite_req_type  axiReq,
    output      axi_lite_rsp_type  axiRsp,
    input  wire logic [5:0]        edgeInputPin,
    input  wire floppy_pins_type   floppyPins,
    output      logic              diskChangedStatusBit,
    output      logic              irq
);

    regs_state_type   state;
    regs_state_type   next_state;
    logic [9:0]       pinLevel;
    logic [9:0]       pinRise;
    logic [9:0]       pinFall;
    logic [5:0]       edgeEvt;
    logic             clr0;
    logic             clr1;
    logic             awHs;
    logic             wHs;
    logic             arHs;
    logic             doWrite;
    logic [9:0]       wrAddr;
    logic [31:0]      wrData;
    logic [3:0]       wrStrb;
    logic             wrLane;
    logic [5:0]       miscClr;
    logic [1:0]       forceSet;
    logic [7:0]       irqClr;
    logic             maskWrite;
    logic [1:0]       forceNew;
    logic             dcNext;
    logic [5:0]       clearOnly;
    logic [5:0]       bothHit;
    logic [2:0]       edgeLow;
    logic [2:0]       edgeHigh;

    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    pin_sync_edge #(
        .WIDTH      (PIN_COUNT),
        .IDLE_LEVEL (PIN_IDLE_LEVEL)
    ) u_sync (
        .clk   (clk),
        .ce    (ce),
        .rst_n (rst_n & standbyRst_n),
        .pinIn ({floppyPins.driveMediaChangedInput_n,
                 floppyPins.drive1SelectStrobe_n,
                 floppyPins.drive0SelectStrobe_n,
                 floppyPins.headStepStrobe_n,
                 edgeInputPin}),
        .level (pinLevel),
        .rise  (pinRise),
        .fall  (pinFall)
    );

    // Either-edge events per edge input
    assign edgeEvt = pinRise[EDGE_COUNT-1:0] | pinFall[EDGE_COUNT-1:0]; // R11
    assign edgeLow  = edgeEvt[2:0];
    assign edgeHigh = edgeEvt[5:3];

    // Strobe release ends the forced indication
    assign clr0 = pinRise[PIN_STEP] | pinRise[PIN_SEL0]; // R8
    assign clr1 = pinRise[PIN_STEP] | pinRise[PIN_SEL1]; // R9

    // ------------------------------------------------------------------
    // AXI4-Lite handshakes and write decode
    // ------------------------------------------------------------------
    assign awHs    = axiReq.awvalid & state.rsp.awready;
    assign wHs     = axiReq.wvalid & state.rsp.wready;
    assign arHs    = axiReq.arvalid & state.rsp.arready;
    assign doWrite = (state.awHeld | awHs) & (state.wHeld | wHs);
    assign wrAddr  = state.awHeld ? state.awAddr : axiReq.awaddr;
    assign wrData  = state.wHeld ? state.wData : axiReq.wdata;
    assign wrStrb  = state.wHeld ? state.wStrb : axiReq.wstrb;
    assign wrLane  = doWrite & wrStrb[0]; // Only byte lane 0 holds data

    // Per-register write effects
    assign miscClr   = (wrLane && wrAddr == ADDR_MISC_STATUS)
                       ? wrData[5:0] : 6'h00; // R1
    assign forceSet  = (wrLane && wrAddr == ADDR_FORCE_CHANGE)
                       ? wrData[1:0] : 2'h0; // R7
    assign irqClr    = (wrLane && wrAddr == ADDR_IRQ_STATUS)
                       ? wrData[7:0] : 8'h00;
    assign maskWrite = wrLane && wrAddr == ADDR_IRQ_MASK;

    // Force bits: hardware clear, software set wins
    assign forceNew = (state.forceChange & ~{clr1, clr0}) | forceSet; // R7

    // Disk changed: media pin low, or forced and selected
    assign dcNext = ~pinLevel[PIN_MEDIA]
                  | (~pinLevel[PIN_SEL0] & forceNew[FORCE_DRIVE0_BIT])
                  | (~pinLevel[PIN_SEL1] & forceNew[FORCE_DRIVE1_BIT]); // R10

    // Helpers for checks
    assign clearOnly = miscClr & ~edgeEvt;
    assign bothHit   = miscClr & edgeEvt;

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    function automatic logic [33:0] readMux(input logic [9:0] addr,
                                            input regs_state_type s);
        logic [33:0] result;
        result = {RESP_OKAY, 32'h0000_0000};
        case (addr)
            ADDR_MISC_STATUS:  result[5:0] = s.miscStatus; // R4
            ADDR_RESERVED_A:   result[31:0] = 32'h0000_0000; // R5
            ADDR_FORCE_CHANGE: result[1:0] = s.forceChange; // R6
            ADDR_IRQ_STATUS:   result[7:0] = s.irqStatus;
            ADDR_IRQ_MASK:     result[7:0] = s.irqMask;
            default:           result[33:32] = RESP_SLVERR;
        endcase
        return result;
    endfunction

    function automatic logic mapped(input logic [9:0] addr);
        logic hit;
        hit = 1'b0;
        case (addr)
            ADDR_MISC_STATUS,
            ADDR_RESERVED_A,
            ADDR_FORCE_CHANGE,
            ADDR_IRQ_STATUS,
            ADDR_IRQ_MASK:     hit = 1'b1;
            default:           hit = 1'b0;
        endcase
        return hit;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        if (ce)
        begin
            // Write channel holding and response
            if (state.rsp.bvalid && axiReq.bready)
            begin
                next_state.rsp.bvalid = 1'b0;
            end
            if (doWrite)
            begin
                next_state.awHeld     = 1'b0;
                next_state.wHeld      = 1'b0;
                next_state.rsp.bvalid = 1'b1;
                next_state.rsp.bresp  = mapped(wrAddr) ? RESP_OKAY
                                                       : RESP_SLVERR;
            end
            else
            begin
                if (awHs)
                begin
                    next_state.awHeld = 1'b1;
                    next_state.awAddr = axiReq.awaddr;
                end
                if (wHs)
                begin
                    next_state.wHeld = 1'b1;
                    next_state.wData = axiReq.wdata;
                    next_state.wStrb = axiReq.wstrb;
                end
            end
            next_state.rsp.awready = ~next_state.awHeld
                                   & ~next_state.rsp.bvalid;
            next_state.rsp.wready  = ~next_state.wHeld
                                   & ~next_state.rsp.bvalid;

            // Read channel, answered right after the address edge
            if (state.rsp.rvalid && axiReq.rready)
            begin
                next_state.rsp.rvalid = 1'b0;
            end
            if (arHs)
            begin
                next_state.rsp.rvalid = 1'b1;
                {next_state.rsp.rresp, next_state.rsp.rdata} =
                    readMux(axiReq.araddr, state);
            end
            next_state.rsp.arready = ~next_state.rsp.rvalid;

            // Sticky edge status, set beats write-one clear
            next_state.miscStatus = (state.miscStatus & ~miscClr)
                                  | edgeEvt; // R1 R2 R3 R11

            // Force bits and disk changed indication
            next_state.forceChange = forceNew; // R8 R9
            next_state.diskChanged = dcNext; // R10

            // Interrupt status: edges and hardware force drops
            next_state.irqStatus = (state.irqStatus & ~irqClr)
                                 | {forceSet[1] ? 1'b0
                                    : state.forceChange[1] & clr1,
                                    forceSet[0] ? 1'b0
                                    : state.forceChange[0] & clr0,
                                    edgeEvt};
            if (maskWrite)
            begin
                next_state.irqMask = wrData[7:0];
            end
            next_state.irq = |(next_state.irqStatus & next_state.irqMask);
        end

        // Main supply reset
        if (!rst_n)
        begin
            next_state.rsp         = '0;
            next_state.awHeld      = 1'b0;
            next_state.awAddr      = 10'h000;
            next_state.wHeld       = 1'b0;
            next_state.wData       = 32'h0000_0000;
            next_state.wStrb       = 4'h0;
            next_state.forceChange = FORCE_RESET;
            next_state.irqStatus   = IRQ_STATUS_RESET;
            next_state.irqMask     = IRQ_MASK_RESET;
            next_state.irq         = 1'b0;
            next_state.diskChanged = 1'b0;
        end

        // Standby supply reset keeps edge status apart
        if (!standbyRst_n)
        begin
            next_state.miscStatus = MISC_RESET;
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        state <= next_state;
    end

    // Outputs straight from flops
    assign axiRsp               = state.rsp;
    assign diskChangedStatusBit = state.diskChanged;
    assign irq                  = state.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !standbyRst_n);

    chk_w1c_clear: assert property ( // R1
        ce && |clearOnly |=> (state.miscStatus & $past(clearOnly)) == 6'h00)
        else $error("misc status bit not cleared by write one");

    chk_edge_low: assert property ( // R2
        ce && |edgeLow |=>
        (state.miscStatus[2:0] & $past(edgeLow)) == $past(edgeLow))
        else $error("low edge status bit not set");

    chk_edge_high: assert property ( // R3
        ce && |edgeHigh |=>
        (state.miscStatus[5:3] & $past(edgeHigh)) == $past(edgeHigh))
        else $error("high edge status bit not set");

    chk_misc_reserved: assert property ( // R4
        ce && arHs && axiReq.araddr == ADDR_MISC_STATUS |=>
        state.rsp.rvalid && state.rsp.rdata[31:6] == 26'h0)
        else $error("misc status upper bits not zero");

    chk_slot_zero: assert property ( // R5
        ce && arHs && axiReq.araddr == ADDR_RESERVED_A |=>
        state.rsp.rdata == 32'h0 && state.rsp.rresp == RESP_OKAY)
        else $error("reserved slot read not zero");

    chk_force_view: assert property ( // R6
        ce && forceNew[0] && !pinLevel[PIN_SEL0] |=> diskChangedStatusBit)
        else $error("forced drive 0 change not shown");

    chk_no_sw_clear: assert property ( // R7
        ce && state.forceChange[1] && !clr1 |=> state.forceChange[1])
        else $error("force bit 1 cleared without hardware cause");

    chk_force0_clear: assert property ( // R8
        ce && clr0 && !forceSet[0] |=> !state.forceChange[0])
        else $error("force bit 0 not cleared by strobe");

    chk_force1_clear: assert property ( // R9
        ce && clr1 && !forceSet[1] |=> !state.forceChange[1])
        else $error("force bit 1 not cleared by strobe");

    chk_media_or: assert property ( // R10
        ce && !pinLevel[PIN_MEDIA] |=> diskChangedStatusBit)
        else $error("media changed input not reflected");

    chk_set_wins: assert property ( // R11
        ce && |bothHit |=>
        (state.miscStatus & $past(bothHit)) == $past(bothHit))
        else $error("edge lost against simultaneous clear");

    chk_irq_level: assert property (
        ce |=> irq == |(state.irqStatus & state.irqMask))
        else $error("interrupt output disagrees with status and mask");

    cover_write_clear: cover property (ce && |clearOnly);
    cover_forced_view: cover property (
        diskChangedStatusBit && pinLevel[PIN_MEDIA]);
    cover_set_wins:    cover property (ce && |bothHit);
    cover_irq_raise:   cover property (ce && !irq ##1 irq);

endmodule // edge_status_disk_change

// ===== pkg/edge_disk_pkg.sv
// Package: register map, reset values, field layout and bus carriers
package edge_disk_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses (byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam int             AXI_ADDR_BITS    = 10;
    localparam logic [7:0]     IDX_MISC_STATUS  = 8'h1C;
    localparam logic [7:0]     IDX_RESERVED_A   = 8'h1D;
    localparam logic [7:0]     IDX_FORCE_CHANGE = 8'h1E;
    localparam logic [7:0]     IDX_IRQ_STATUS   = 8'h20;
    localparam logic [7:0]     IDX_IRQ_MASK     = 8'h21;
    localparam logic [9:0]     ADDR_MISC_STATUS  = {IDX_MISC_STATUS, 2'h0};
    localparam logic [9:0]     ADDR_RESERVED_A   = {IDX_RESERVED_A, 2'h0};
    localparam logic [9:0]     ADDR_FORCE_CHANGE = {IDX_FORCE_CHANGE, 2'h0};
    localparam logic [9:0]     ADDR_IRQ_STATUS   = {IDX_IRQ_STATUS, 2'h0};
    localparam logic [9:0]     ADDR_IRQ_MASK     = {IDX_IRQ_MASK, 2'h0};

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [5:0]     MISC_RESET       = 6'h00;
    localparam logic [1:0]     FORCE_RESET      = 2'h1;
    localparam logic [7:0]     IRQ_STATUS_RESET = 8'h00;
    localparam logic [7:0]     IRQ_MASK_RESET   = 8'h00;
    localparam int             EDGE_COUNT       = 6;
    localparam int             FORCE_DRIVE0_BIT = 0;
    localparam int             FORCE_DRIVE1_BIT = 1;
    localparam int             IRQ_FORCE0_BIT   = 6;
    localparam int             IRQ_FORCE1_BIT   = 7;

    // Positions in the synchroniser vector
    localparam int             PIN_COUNT        = 10;
    localparam int             PIN_STEP         = 6;
    localparam int             PIN_SEL0         = 7;
    localparam int             PIN_SEL1         = 8;
    localparam int             PIN_MEDIA        = 9;
    localparam logic [9:0]     PIN_IDLE_LEVEL   = 10'h3C0;
    localparam int             SYNC_ARM_CYCLES  = 2;

    // AXI response codes
    localparam logic [1:0]     RESP_OKAY        = 2'h0;
    localparam logic [1:0]     RESP_SLVERR      = 2'h2;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [9:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [9:0]  araddr;
        logic        arvalid;
        logic        rready;
    } axi_lite_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_lite_rsp_type;

    typedef struct packed {
        logic headStepStrobe_n;
        logic drive0SelectStrobe_n;
        logic drive1SelectStrobe_n;
        logic driveMediaChangedInput_n;
    } floppy_pins_type;

    typedef struct packed {
        axi_lite_rsp_type rsp;
        logic             awHeld;
        logic [9:0]       awAddr;
        logic             wHeld;
        logic [31:0]      wData;
        logic [3:0]       wStrb;
        logic [5:0]       miscStatus;
        logic [1:0]       forceChange;
        logic [7:0]       irqStatus;
        logic [7:0]       irqMask;
        logic             irq;
        logic             diskChanged;
    } regs_state_type;

endpackage

// ===== design/pin_sync_edge.sv
// Two-flop pin synchroniser with armed rise and fall detection
`timescale 1ns/10ps

module pin_sync_edge
    import edge_disk_pkg::*;
#(
    parameter int               WIDTH      = PIN_COUNT,
    parameter logic [WIDTH-1:0] IDLE_LEVEL = '0
)
(
    input  wire logic             clk,
    input  wire logic             ce,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pinIn,
    output      logic [WIDTH-1:0] level,
    output      logic [WIDTH-1:0] rise,
    output      logic [WIDTH-1:0] fall
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] prev;
        logic [1:0]       armCount;
    } sync_state_type;

    sync_state_type state;
    sync_state_type next_state;
    logic           armed;

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (WIDTH < 1)
    begin : g_bad_width
        $error("pin_sync_edge needs at least one pin");
    end

    // Edges count once stable holds a sampled level; prev may still hold IDLE_LEVEL then
    assign armed = (state.armCount >= 2'(SYNC_ARM_CYCLES));

    // Per-bit edge decode from the second and third stages
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        assign level[i] = state.stable[i];
        assign rise[i]  = armed & state.stable[i] & ~state.prev[i];
        assign fall[i]  = armed & ~state.stable[i] & state.prev[i];
    end

    // Shift chain; meta feeds stable only
    always_comb
    begin
        next_state = state;
        if (ce)
        begin
            next_state.meta   = pinIn;
            next_state.stable = state.meta;
            next_state.prev   = state.stable;
            if (!armed)
            begin
                next_state.armCount = state.armCount + 2'h1;
            end
        end
        if (!rst_n)
        begin
            next_state.meta     = IDLE_LEVEL;
            next_state.stable   = IDLE_LEVEL;
            next_state.prev     = IDLE_LEVEL;
            next_state.armCount = 2'h0;
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        state <= next_state;
    end

endmodule // pin_sync_edge

// ===== verification/floppy_pin_model.sv
// Model of the pins and floppy drive strobes facing the register block
`timescale 1ns/10ps

module floppy_pin_model
    import edge_disk_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [5:0] edgeLevel,
    input  wire logic       stepPulse,
    input  wire logic       sel0,
    input  wire logic       sel1,
    input  wire logic       mediaChanged,
    output      logic [5:0] edgeInputPin,
    output      floppy_pins_type floppyPins
);
    logic [1:0] stepCount;

    // Pins follow the requested levels a cycle late; step is a 2-cycle low
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            edgeInputPin <= 6'h00;
            floppyPins   <= 4'hF;
            stepCount    <= 2'h0;
        end
        else
        begin
            edgeInputPin <= edgeLevel;
            stepCount    <= stepPulse ? 2'h2 : stepCount - (stepCount != 0);
            floppyPins.headStepStrobe_n         <= !(stepPulse
                                                     || stepCount > 1);
            floppyPins.drive0SelectStrobe_n     <= !sel0;
            floppyPins.drive1SelectStrobe_n     <= !sel1;
            floppyPins.driveMediaChangedInput_n <= !mediaChanged;
        end
    end
endmodule // floppy_pin_model

// ===== verification/edge_status_disk_change_test.sv
// Self-checking bench for the edge status and disk change registers
`timescale 1ns/10ps

`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end

module edge_status_disk_change_test;
    import edge_disk_pkg::*;

    logic             clk, ce, rst_n, standbyRst_n, diskChanged, irq;
    logic             stepPulse, sel0, sel1, mediaChanged;
    logic [5:0]       edgeLevel, edgeInputPin;
    axi_lite_req_type axiReq;
    axi_lite_rsp_type axiRsp;
    floppy_pins_type  floppyPins;
    int               mismatches, numChecks;
    logic [1:0]       resp;

    // ------------------------------------------------------------------
    // Instances and clock
    // ------------------------------------------------------------------
    edge_status_disk_change u_edge_status_disk_change (.clk(clk), .ce(ce),
        .rst_n(rst_n), .standbyRst_n(standbyRst_n), .axiReq(axiReq),
        .axiRsp(axiRsp), .edgeInputPin(edgeInputPin),
        .floppyPins(floppyPins), .diskChangedStatusBit(diskChanged),
        .irq(irq));
    floppy_pin_model u_floppy_pin_model (.clk(clk), .rst_n(rst_n),
        .edgeLevel(edgeLevel), .stepPulse(stepPulse), .sel0(sel0),
        .sel1(sel1), .mediaChanged(mediaChanged),
        .edgeInputPin(edgeInputPin), .floppyPins(floppyPins));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        axiReq.awaddr <= a;
        axiReq.wdata  <= {24'h000000, d};
        axiReq.wstrb  <= 4'hF;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        axiReq.bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
            if (axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
        end
        while (axiRsp.bvalid !== 1'b1);
        resp = axiRsp.bresp;
        axiReq.bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        axiReq.araddr  <= a;
        axiReq.arvalid <= 1'b1;
        axiReq.rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
        end
        while (axiRsp.rvalid !== 1'b1);
        d = axiRsp.rdata;
        resp = axiRsp.rresp;
        axiReq.rready <= 1'b0;
        @(posedge clk);
    endtask

    // Read a register and compare data and an OKAY response
    task automatic expect_reg(input logic [9:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        `CHK(d, e)
        `CHK(resp, RESP_OKAY)
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    initial
    begin
        #200us;
        mismatches++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        logic [31:0] d;
        axiReq = '0;
        rst_n = 1'b0;
        standbyRst_n = 1'b0;
        ce = 1'b1;
        edgeLevel = 6'h00;
        {stepPulse, sel0, sel1, mediaChanged} = 4'h0;
        ticks(16);
        rst_n <= 1'b1;
        standbyRst_n <= 1'b1;
        ticks(4);
        // Reset values, reserved slot and unmapped address
        expect_reg(ADDR_MISC_STATUS, 32'h00000000);
        expect_reg(ADDR_FORCE_CHANGE, 32'h00000001);
        wr(ADDR_RESERVED_A, 8'hFF);
        expect_reg(ADDR_RESERVED_A, 32'h00000000);
        rd(10'h3F0, d);
        `CHK(resp, RESP_SLVERR)
        $display("test reset values done");
        // Either edge on every input, then write-one clear
        edgeLevel <= 6'h3F;
        ticks(8);
        expect_reg(ADDR_MISC_STATUS, 32'h0000003F);
        wr(ADDR_MISC_STATUS, 8'hC5);
        expect_reg(ADDR_MISC_STATUS, 32'h0000003A);
        wr(ADDR_MISC_STATUS, 8'h00);
        expect_reg(ADDR_MISC_STATUS, 32'h0000003A);
        wr(ADDR_MISC_STATUS, 8'h3A);
        edgeLevel <= 6'h00;
        ticks(8);
        expect_reg(ADDR_MISC_STATUS, 32'h0000003F);
        standbyRst_n <= 1'b0;
        ticks(3);
        standbyRst_n <= 1'b1;
        ticks(4);
        expect_reg(ADDR_MISC_STATUS, 32'h00000000);
        $display("test edge status done");
        // Force bits: set only by software, cleared by strobe activity
        wr(ADDR_FORCE_CHANGE, 8'h02);
        expect_reg(ADDR_FORCE_CHANGE, 32'h00000003);
        wr(ADDR_FORCE_CHANGE, 8'h00);
        expect_reg(ADDR_FORCE_CHANGE, 32'h00000003);
        `CHK(diskChanged, 1'b0)
        sel0 <= 1'b1;
        ticks(8);
        `CHK(diskChanged, 1'b1)
        sel0 <= 1'b0;
        ticks(8);
        expect_reg(ADDR_FORCE_CHANGE, 32'h00000002);
        sel1 <= 1'b1;
        ticks(8);
        `CHK(diskChanged, 1'b1)
        sel1 <= 1'b0;
        ticks(8);
        expect_reg(ADDR_FORCE_CHANGE, 32'h00000000);
        wr(ADDR_FORCE_CHANGE, 8'h03);
        stepPulse <= 1'b1;
        @(posedge clk);
        stepPulse <= 1'b0;
        ticks(8);
        expect_reg(ADDR_FORCE_CHANGE, 32'h00000000);
        mediaChanged <= 1'b1;
        ticks(8);
        `CHK(diskChanged, 1'b1)
        mediaChanged <= 1'b0;
        ticks(8);
        `CHK(diskChanged, 1'b0)
        $display("test force change done");
        // Interrupt raised by an unmasked event, cleared by write-one
        wr(ADDR_IRQ_STATUS, 8'hFF);
        wr(ADDR_IRQ_MASK, 8'h01);
        edgeLevel <= 6'h02;
        ticks(8);
        `CHK(irq, 1'b0)
        edgeLevel <= 6'h03;
        ticks(8);
        `CHK(irq, 1'b1)
        wr(ADDR_IRQ_STATUS, 8'h01);
        ticks(2);
        `CHK(irq, 1'b0)
        // Clock enable low freezes capture; the edge lands once it returns
        ce <= 1'b0;
        edgeLevel <= 6'h02;
        ticks(8);
        `CHK(irq, 1'b0)
        ce <= 1'b1;
        ticks(8);
        `CHK(irq, 1'b1)
        $display("test interrupt done");
        report_and_stop();
    end
endmodule // edge_status_disk_change_test
